/* File: include/alec_pkg.sv */
// shared constants and types for the line error counter record
package alec_pkg;
  // record layout, byte offsets
  localparam int OFS_VER = 0;         // version, two bytes
  localparam int OFS_PWR = 2;         // power-fail counter, two bytes
  localparam int OFS_GND = 4;         // ground-short counter, two bytes
  localparam int OFS_C32 = 6;         // first 32-bit counter
  localparam int C32_STRIDE = 4;      // bytes per 32-bit counter
  localparam int OFS_MAP_A = 30;      // single/A slave bitmap, four bytes
  localparam int OFS_MAP_B = 34;      // B slave bitmap, four bytes
  localparam int OFS_LAST32 = 29;     // low byte of the final counter
  localparam int REC_LEN = 38;        // bytes in the record
  localparam int N16 = 2;             // number of 16-bit counters
  localparam int N32 = 6;             // number of 32-bit counters
  localparam int MAP_BYTES = 4;       // bytes per bitmap half
  localparam int IDX_W = 6;           // width of a record byte index
  localparam int SLV_W = 5;           // width of a slave address
  localparam int NSLV = 32;           // slaves per bitmap half
  localparam logic [15:0] VERSION = 16'h0000; // record version
  localparam logic [7:0] ZERO_BYTE = 8'h00;   // answer for bytes past end

  // one-cycle event strobes from the line side
  typedef struct packed {
    logic power_fail;                 // supply missing, low or unstable
    logic ground_short;               // conductor A or B shorted to ground
    logic slave_fail;                 // slave dropped from activated set
    logic miss_frame;                 // no reply from a present slave
    logic bad_frame;                  // reply mutilated or corrupt
    logic periph_fault;               // peripheral fault in status reply
    logic protocol_err;               // combined-transaction transfer fault
    logic bad_master;                 // own send frame read back wrong
    logic [SLV_W-1:0] slave_addr;     // slave the event concerns
    logic slave_b;                    // slave is a B-type address
  } alec_evt_t;

  // byte read request from the controller
  typedef struct packed {
    logic req;                        // read strobe
    logic [IDX_W-1:0] index;          // record byte index
  } alec_rd_t;
endpackage

/* File: src/alec_counter.sv */
// saturating event counter of configurable width
`timescale 1ns/1ns
`default_nettype none
module alec_counter #(
  parameter int W = 16                // counter width
) (
  input wire logic clk,               // system clock
  input wire logic resetn,            // asynchronous reset, active low
  input wire logic inc,               // one event this cycle
  output logic [W-1:0] count          // current count
);
  // add one per event, hold at the top value
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
    end else if (inc && (count != {W{1'b1}})) begin
      count <= count + W'(1);
    end
  end
endmodule
`default_nettype wire

/* File: src/alec_top.sv */
// line error counters with per-slave bitmap, read as a byte record
`timescale 1ns/1ns
`default_nettype none
module alec_top #(
  parameter int W16 = 16,             // width of the supply counters
  parameter int W32 = 32              // width of the frame counters
) (
  input wire logic CLK,               // system clock, 100 MHz
  input wire logic RESETN,            // asynchronous reset, active low
  input wire alec_pkg::alec_evt_t EVT, // event strobes from the line side
  input wire alec_pkg::alec_rd_t RD,  // byte read request
  output logic RD_VALID,              // read answer strobe
  output logic [7:0] RD_DATA,         // read answer byte
  output logic [31:0] MAP_A,          // single/A slave error bitmap
  output logic [31:0] MAP_B           // B slave error bitmap
);
  logic [W16-1:0] cnt16 [alec_pkg::N16];
  logic [W32-1:0] cnt32 [alec_pkg::N32];
  logic [alec_pkg::N16-1:0] ev16;
  logic [alec_pkg::N32-1:0] ev32;
  logic slave_hit;
  logic [7:0] rec [alec_pkg::REC_LEN];

  // event strobes grouped by counter width, in record order
  assign ev16 = {EVT.ground_short, EVT.power_fail};
  assign ev32 = {EVT.bad_master, EVT.protocol_err,
                 EVT.periph_fault, EVT.bad_frame,
                 EVT.miss_frame, EVT.slave_fail};
  assign slave_hit = EVT.slave_fail | EVT.miss_frame | EVT.bad_frame |
                     EVT.periph_fault | EVT.protocol_err;

  // one counter per error kind
  for (genvar i = 0; i < alec_pkg::N16; i++) begin : g_c16
    alec_counter #(.W(W16)) u_cnt (
      .clk(CLK),
      .resetn(RESETN),
      .inc(ev16[i]),
      .count(cnt16[i])
    );
  end
  for (genvar i = 0; i < alec_pkg::N32; i++) begin : g_c32
    alec_counter #(.W(W32)) u_cnt (
      .clk(CLK),
      .resetn(RESETN),
      .inc(ev32[i]),
      .count(cnt32[i])
    );
  end

  // sticky per-slave bitmaps, set one cycle after the event
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      MAP_A <= 32'h0000_0000;
      MAP_B <= 32'h0000_0000;
    end else if (slave_hit) begin
      if (EVT.slave_b) begin
        MAP_B[EVT.slave_addr] <= 1'b1;
      end else begin
        MAP_A[EVT.slave_addr] <= 1'b1;
      end
    end
  end

  // assemble the record image
  always_comb begin
    for (int b = 0; b < alec_pkg::REC_LEN; b++) begin
      rec[b] = alec_pkg::ZERO_BYTE;
    end
    rec[alec_pkg::OFS_VER] = alec_pkg::VERSION[15:8];
    rec[alec_pkg::OFS_VER+1] = alec_pkg::VERSION[7:0];
    rec[alec_pkg::OFS_PWR] = cnt16[0][15:8];
    rec[alec_pkg::OFS_PWR+1] = cnt16[0][7:0];
    rec[alec_pkg::OFS_GND] = cnt16[1][15:8];
    rec[alec_pkg::OFS_GND+1] = cnt16[1][7:0];
    for (int c = 0; c < alec_pkg::N32; c++) begin
      for (int k = 0; k < alec_pkg::C32_STRIDE; k++) begin
        rec[alec_pkg::OFS_C32 + alec_pkg::C32_STRIDE*c + k] =
          cnt32[c][31-8*k -: 8];
      end
    end
    for (int m = 0; m < alec_pkg::MAP_BYTES; m++) begin
      rec[alec_pkg::OFS_MAP_A + m] = MAP_A[8*m +: 8];
      rec[alec_pkg::OFS_MAP_B + m] = MAP_B[8*m +: 8];
    end
  end

  // answer strobe one cycle after each request
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      RD_VALID <= 1'b0;
    end else begin
      RD_VALID <= RD.req;
    end
  end

  // registered read data, zero past the end of the record
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      RD_DATA <= alec_pkg::ZERO_BYTE;
    end else if (RD.req) begin
      if (int'(RD.index) < alec_pkg::REC_LEN) begin
        RD_DATA <= rec[RD.index];
      end else begin
        RD_DATA <= alec_pkg::ZERO_BYTE;
      end
    end
  end

  // checks on bitmap, counters and record layout
  property p_map_a;
    @(posedge CLK) disable iff (!RESETN)
    (slave_hit && !EVT.slave_b) |=> MAP_A[$past(EVT.slave_addr)];
  endproperty
  a_map_a: assert property (p_map_a)
    else $error("A bitmap bit not set by slave event");

  property p_map_b;
    @(posedge CLK) disable iff (!RESETN)
    (slave_hit && EVT.slave_b) |=> MAP_B[$past(EVT.slave_addr)] &&
      $stable(MAP_A);
  endproperty
  a_map_b: assert property (p_map_b)
    else $error("B bitmap bit not set or A bitmap disturbed");

  property p_map_cause;
    @(posedge CLK) disable iff (!RESETN)
    !slave_hit |=> $stable(MAP_A) && $stable(MAP_B);
  endproperty
  a_map_cause: assert property (p_map_cause)
    else $error("bitmap changed without a slave event");

  property p_pwr;
    @(posedge CLK) disable iff (!RESETN)
    (EVT.power_fail && cnt16[0] != '1) |=> cnt16[0] == $past(cnt16[0]) + 1'b1;
  endproperty
  a_pwr: assert property (p_pwr)
    else $error("power-fail counter did not step");

  property p_gnd;
    @(posedge CLK) disable iff (!RESETN)
    !EVT.ground_short |=> cnt16[1] == $past(cnt16[1]);
  endproperty
  a_gnd: assert property (p_gnd)
    else $error("ground-short counter moved without event");

  property p_slave_fail;
    @(posedge CLK) disable iff (!RESETN)
    (EVT.slave_fail && cnt32[0] != '1) |=> cnt32[0] == $past(cnt32[0]) + 1'b1;
  endproperty
  a_slave_fail: assert property (p_slave_fail)
    else $error("slave-failure counter did not step");

  property p_frames;
    @(posedge CLK) disable iff (!RESETN)
    (EVT.miss_frame && !EVT.bad_frame && cnt32[1] != '1) |=>
      cnt32[1] == $past(cnt32[1]) + 1'b1 && cnt32[2] == $past(cnt32[2]);
  endproperty
  a_frames: assert property (p_frames)
    else $error("missing or bad frame counter wrong");

  property p_periph;
    @(posedge CLK) disable iff (!RESETN)
    (EVT.periph_fault && cnt32[3] != '1) |=>
      cnt32[3] == $past(cnt32[3]) + 1'b1;
  endproperty
  a_periph: assert property (p_periph)
    else $error("peripheral error counter did not step");

  property p_proto;
    @(posedge CLK) disable iff (!RESETN)
    (EVT.protocol_err && cnt32[4] != '1) |=>
      cnt32[4] == $past(cnt32[4]) + 1'b1;
  endproperty
  a_proto: assert property (p_proto)
    else $error("protocol error counter did not step");

  property p_master;
    @(posedge CLK) disable iff (!RESETN)
    (EVT.bad_master && cnt32[5] != '1) |=> cnt32[5] == $past(cnt32[5]) + 1'b1;
  endproperty
  a_master: assert property (p_master)
    else $error("bad master frame counter did not step");

  property p_rd_version;
    @(posedge CLK) disable iff (!RESETN)
    (RD.req && RD.index < 6'(alec_pkg::OFS_PWR)) |=>
      RD_VALID && RD_DATA == 8'h00;
  endproperty
  a_rd_version: assert property (p_rd_version)
    else $error("version byte not zero");

  property p_rd_pwr_hi;
    @(posedge CLK) disable iff (!RESETN)
    (RD.req && RD.index == 6'(alec_pkg::OFS_PWR)) |=>
      RD_DATA == $past(cnt16[0][15:8]);
  endproperty
  a_rd_pwr_hi: assert property (p_rd_pwr_hi)
    else $error("power-fail high byte misplaced");

  property p_rd_last;
    @(posedge CLK) disable iff (!RESETN)
    (RD.req && RD.index == 6'(alec_pkg::OFS_LAST32)) |=>
      RD_DATA == $past(cnt32[5][7:0]);
  endproperty
  a_rd_last: assert property (p_rd_last)
    else $error("final counter low byte misplaced");

  property p_rd_first32;
    @(posedge CLK) disable iff (!RESETN)
    (RD.req && RD.index == 6'(alec_pkg::OFS_C32)) |=>
      RD_DATA == $past(cnt32[0][31:24]);
  endproperty
  a_rd_first32: assert property (p_rd_first32)
    else $error("slave-failure high byte misplaced");
endmodule
`default_nettype wire

/* File: testbench/alec_ctl_model.sv */
// controller model that fetches single bytes of the error record
`timescale 1ns/1ns
`default_nettype none
module alec_ctl_model (
  input wire logic clk,                // system clock
  output var alec_pkg::alec_rd_t rd,   // read request
  input wire logic rd_valid,           // answer strobe
  input wire logic [7:0] rd_data       // answer byte
);
  // request idle from time zero
  initial begin
    rd = '0;
  end
  // one request edge, answer taken at the following edge
  task automatic read_byte(input logic [5:0] idx, output logic [7:0] d,
                           output logic ok);
    @(posedge clk);
    rd <= '{req: 1'b1, index: idx};
    @(posedge clk);
    rd <= '{req: 1'b0, index: ~idx};   // released index shows other bits
    @(posedge clk);
    ok = rd_valid;
    d = rd_data;
  endtask
endmodule
`default_nettype wire

/* File: testbench/asi_line_error_counters_test.sv */
// self-checking bench for the line error counter record
`timescale 1ns/1ns
`default_nettype none
module asi_line_error_counters_test;
  logic CLK = 1'b0;
  logic RESETN = 1'b0;
  alec_pkg::alec_evt_t EVT = '0;
  alec_pkg::alec_rd_t RD;
  logic RD_VALID;
  logic [7:0] RD_DATA;
  logic [31:0] MAP_A;
  logic [31:0] MAP_B;
  int n_fail = 0;
  int check_count = 0;
  logic [15:0] c16 [2];
  logic [31:0] c32 [6];
  logic [31:0] ma;
  logic [31:0] mb;
  // free running clock
  always #5 CLK = ~CLK;
  alec_top dut (.CLK(CLK), .RESETN(RESETN), .EVT(EVT), .RD(RD),
    .RD_VALID(RD_VALID), .RD_DATA(RD_DATA), .MAP_A(MAP_A), .MAP_B(MAP_B));
  alec_ctl_model ctl (.clk(CLK), .rd(RD), .rd_valid(RD_VALID),
    .rd_data(RD_DATA));
  // expected record byte from the bench's own counts
  function automatic logic [7:0] exp_byte(input int i);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (i < 2) w = {16'h0000, alec_pkg::VERSION} >> (8 * (1 - i));
    else if (i < 6) w = {16'h0000, c16[(i-2)/2]} >> (8 * (1 - i % 2));
    else if (i < 30) w = c32[(i-6)/4] >> (8 * (3 - (i-6) % 4));
    else if (i < 34) w = ma >> (8 * (i - 30));
    else if (i < 38) w = mb >> (8 * (i - 34));
    return w[7:0];
  endfunction
  // byte comparison
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bitmap word comparison
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // expected state after reset
  task automatic clr_exp;
    c16 = '{default: 16'h0000};
    c32 = '{default: 32'h0000_0000};
    ma = 32'h0000_0000;
    mb = 32'h0000_0000;
  endtask
  // read whole record plus two bytes past its end
  task automatic check_rec(input string name);
    logic [7:0] d;
    logic ok;
    for (int i = 0; i < 40; i++) begin
      ctl.read_byte(i[5:0], d, ok);
      chk8({7'h00, ok}, 8'h01);
      chk8(d, exp_byte(i));
    end
    chk32(MAP_A, ma);
    chk32(MAP_B, mb);
    $display("test %s done", name);
  endtask
  // hold strobes for n cycles, one event per cycle
  task automatic pulse(input alec_pkg::alec_evt_t e, input int n);
    @(posedge CLK);
    EVT <= e;
    repeat (n - 1) @(posedge CLK);
    @(posedge CLK);
    EVT <= '0;
  endtask
  // verdict and end of run
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // cut a hang short
  initial begin
    #50000;
    n_fail++;
    report_and_stop;
  end
  // main sequence
  initial begin
    logic [4:0] a;
    logic b;
    clr_exp;
    repeat (2) @(posedge CLK);
    RESETN <= 1'b1;
    check_rec("reset");
    for (int k = 0; k < 8; k++) begin
      a = 5'(k * 9);
      b = k[0];
      pulse({8'h80 >> k, a, b}, k + 1);
      if (k < 2) c16[k] += 16'(k + 1);
      else c32[k-2] += 32'(k + 1);
      if (k >= 2 && k <= 6 && b) mb[a] = 1'b1;
      else if (k >= 2 && k <= 6) ma[a] = 1'b1;
    end
    check_rec("each_event");
    pulse({8'hff, 5'h1f, 1'b1}, 1);
    for (int k = 0; k < 6; k++) c32[k] += 32'h0000_0001;
    c16[0] += 16'h0001;
    c16[1] += 16'h0001;
    mb[31] = 1'b1;
    check_rec("all_at_once");
    @(posedge CLK);
    RESETN <= 1'b0;
    repeat (2) @(posedge CLK);
    RESETN <= 1'b1;
    clr_exp;
    check_rec("second_reset");
    report_and_stop;
  end
endmodule
`default_nettype wire
